// ---- hw/amt_params.svh ----
// amt_params.svh: constants of the announcement modulator timer.
// assumes a 50 MHz ref_clk and a mains-derived line-cycle input.
`ifndef AMT_PARAMS_SVH
`define AMT_PARAMS_SVH

`define AMT_REF_HZ        50000000
`define AMT_LINE_HZ       60
`define AMT_ON_SHORT_S    30
`define AMT_ON_LONG_S     60
`define AMT_INT_SHORT_MIN 60
`define AMT_INT_LONG_MIN  120
`define AMT_RELAY_S       1
`define AMT_TONE_MS       500
`define AMT_ON_W          12
`define AMT_INT_W         19
`define AMT_RELAY_W       7
`define AMT_TONE_W        25

`endif

// ---- hw/amt_pkg.sv ----
// amt_pkg: state types of the announcement modulator timer.
// assumes amt_params.svh is on the include path.
`include "amt_params.svh"

package amt_pkg;

    typedef enum logic {
        AMT_OFF,
        AMT_ON
    } amt_state_t;

    typedef struct packed {
        amt_state_t               st;
        logic                     trig_d;
        logic                     cancel_d;
        logic                     line_d;
        logic                     tone_done;
        logic [`AMT_ON_W-1:0]     on_cnt;
        logic [`AMT_INT_W-1:0]    int_cnt;
        logic [`AMT_RELAY_W-1:0]  relay_cnt;
        logic [`AMT_TONE_W-1:0]   tone_cnt;
        logic                     mod_on;
        logic                     relay_close;
    } amt_reg_t;

endpackage : amt_pkg

// ---- hw/amt_timer.sv ----
// amt_timer: on/off sequencer of the local announcement modulator.
// assumes all inputs are synchronous to ref_clk; terminals active low.
`timescale 1ns/1ns
`include "amt_params.svh"

module amt_timer #(
    parameter int ON_SHORT_CYC  = `AMT_ON_SHORT_S * `AMT_LINE_HZ,
    parameter int ON_LONG_CYC   = `AMT_ON_LONG_S * `AMT_LINE_HZ,
    parameter int INT_SHORT_CYC = `AMT_INT_SHORT_MIN * 60 * `AMT_LINE_HZ,
    parameter int INT_LONG_CYC  = `AMT_INT_LONG_MIN * 60 * `AMT_LINE_HZ,
    parameter int RELAY_CYC     = `AMT_RELAY_S * `AMT_LINE_HZ,
    parameter int TONE_CYC      = (`AMT_REF_HZ / 1000) * `AMT_TONE_MS
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // mains line-cycle square wave
    input  wire logic line_cycle_in,
    // rear terminal contacts, grounded when active
    input  wire logic manual_trigger_input_n,
    input  wire logic manual_cancel_input_n,
    // tone decoder
    input  wire logic tone_detect,
    input  wire logic tone_enable_switch,
    input  wire logic tone_turns_off,
    // jumpers and cycle-time selector
    input  wire logic interval_jumper,
    input  wire logic relay_hold_jumper,
    input  wire logic on_time_60s_sel,
    // outputs
    output logic      modulator_on,
    output logic      relay_close
);
    import amt_pkg::*;

    amt_reg_t s_r;
    amt_reg_t s_nxt;

    logic                    line_tick;
    logic                    trig_fall;
    logic                    cancel_fall;
    logic                    tone_fire;
    logic                    tone_act;
    logic                    tone_deact;
    logic                    int_fire;
    logic                    on_expire;
    logic                    activate;
    logic                    deactivate;
    logic [`AMT_ON_W-1:0]    on_lim;
    logic [`AMT_INT_W-1:0]   int_lim;

    // timing steps on mains cycles, so accuracy tracks the utility
    assign line_tick = line_cycle_in & ~s_r.line_d;

    // edges only: a held contact acts once and no more
    assign trig_fall   = s_r.trig_d & ~manual_trigger_input_n;
    assign cancel_fall = s_r.cancel_d & ~manual_cancel_input_n;

    // longer on-time doubles the interval
    assign on_lim  = on_time_60s_sel ? `AMT_ON_W'(ON_LONG_CYC)
                                     : `AMT_ON_W'(ON_SHORT_CYC);
    assign int_lim = on_time_60s_sel ? `AMT_INT_W'(INT_LONG_CYC)
                                     : `AMT_INT_W'(INT_SHORT_CYC);

    // tone acts once per burst, after it has stood long enough
    assign tone_fire = tone_enable_switch & tone_detect & ~s_r.tone_done
                     & (s_r.tone_cnt == `AMT_TONE_W'(TONE_CYC - 1));
    // one function per setting, selected by a single strap
    assign tone_act   = tone_fire & ~tone_turns_off;
    assign tone_deact = tone_fire & tone_turns_off;

    assign int_fire  = interval_jumper & line_tick
                     & (s_r.int_cnt == int_lim - `AMT_INT_W'(1));
    assign on_expire = line_tick
                     & (s_r.on_cnt == on_lim - `AMT_ON_W'(1));

    // trigger stays live whether or not the interval runs
    assign activate   = (s_r.st == AMT_OFF)
                      & (trig_fall | int_fire | tone_act);
    // cancel, tone or timeout, whichever comes first
    assign deactivate = (s_r.st == AMT_ON)
                      & (cancel_fall | tone_deact | on_expire);

    always_comb begin
        s_nxt           = s_r;
        s_nxt.trig_d    = manual_trigger_input_n;
        s_nxt.cancel_d  = manual_cancel_input_n;
        s_nxt.line_d    = line_cycle_in;

        // tone qualifier runs on ref_clk for a finer half second
        if (!tone_detect || !tone_enable_switch) begin
            s_nxt.tone_cnt  = '0;
            s_nxt.tone_done = 1'b0;
        end else if (tone_fire) begin
            s_nxt.tone_done = 1'b1;
        end else if (!s_r.tone_done) begin
            s_nxt.tone_cnt = s_r.tone_cnt + `AMT_TONE_W'(1);
        end

        case (s_r.st)
            AMT_OFF: begin
                // interval only counts while the modulator rests
                if (!interval_jumper) begin
                    s_nxt.int_cnt = '0;
                end else if (line_tick) begin
                    s_nxt.int_cnt = s_r.int_cnt + `AMT_INT_W'(1);
                end
                if (activate) begin
                    s_nxt.st        = AMT_ON;
                    s_nxt.on_cnt    = '0;
                    s_nxt.relay_cnt = '0;
                    s_nxt.int_cnt   = '0;
                end
            end
            AMT_ON: begin
                if (line_tick) begin
                    s_nxt.on_cnt = s_r.on_cnt + `AMT_ON_W'(1);
                    if (s_r.relay_cnt != `AMT_RELAY_W'(RELAY_CYC)) begin
                        s_nxt.relay_cnt = s_r.relay_cnt + `AMT_RELAY_W'(1);
                    end
                end
                if (deactivate) begin
                    s_nxt.st      = AMT_OFF;
                    s_nxt.on_cnt  = '0;
                    s_nxt.int_cnt = '0;
                end
            end
            default: begin
                s_nxt.st = AMT_OFF;
            end
        endcase

        s_nxt.mod_on = (s_nxt.st == AMT_ON);
        // pulse about one second, or hold for the whole on-time
        s_nxt.relay_close = s_nxt.mod_on
            & (relay_hold_jumper
               | (s_nxt.relay_cnt != `AMT_RELAY_W'(RELAY_CYC)));
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r          <= '0;
            s_r.st       <= AMT_OFF;
            // contacts assumed open, so a ground held through reset counts as an edge at release
            s_r.trig_d   <= 1'b1;
            s_r.cancel_d <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign modulator_on = s_r.mod_on;
    assign relay_close  = s_r.relay_close;

    AST_TRIG_ON: assert property (@(posedge ref_clk) disable iff (rst)
        !s_r.mod_on && trig_fall |=> s_r.mod_on)
        else $error("trigger edge did not switch modulator on");

    AST_ON_BOUND: assert property (@(posedge ref_clk) disable iff (rst)
        s_r.mod_on |-> s_r.on_cnt < on_lim)
        else $error("on-time counter passed its limit");

    AST_TIMEOUT: assert property (@(posedge ref_clk) disable iff (rst)
        s_r.mod_on && line_tick && s_r.on_cnt == on_lim - `AMT_ON_W'(1)
        |=> !s_r.mod_on)
        else $error("modulator outlived its on-time");

    AST_CANCEL: assert property (@(posedge ref_clk) disable iff (rst)
        s_r.mod_on && cancel_fall |=> !s_r.mod_on ##1 !s_r.relay_close)
        else $error("cancel did not switch modulator off");

    AST_INT_RESTART: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(s_r.mod_on) |-> s_r.int_cnt == '0)
        else $error("interval not restarted at deactivation");

    AST_MANUAL_RESTART: assert property (@(posedge ref_clk)
        disable iff (rst)
        !s_r.mod_on && trig_fall |=> s_r.int_cnt == '0)
        else $error("manual activation kept interval count");

    AST_NO_AUTO: assert property (@(posedge ref_clk) disable iff (rst)
        !s_r.mod_on && !interval_jumper && !trig_fall && !tone_act
        |=> !s_r.mod_on)
        else $error("activation without a cause");

    AST_TONE_GATE: assert property (@(posedge ref_clk) disable iff (rst)
        !s_r.mod_on && !tone_enable_switch && !trig_fall && !int_fire
        |=> !s_r.mod_on)
        else $error("tone acted with tone switch off");

    AST_TONE_QUAL: assert property (@(posedge ref_clk) disable iff (rst)
        tone_fire |-> $past(tone_detect) && $past(tone_enable_switch))
        else $error("tone acted without sustained detection");

    AST_TONE_OFF: assert property (@(posedge ref_clk) disable iff (rst)
        s_r.mod_on && tone_deact |=> !s_r.mod_on)
        else $error("qualified tone did not switch modulator off");

    AST_RELAY_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s_r.mod_on) |-> s_r.relay_close)
        else $error("relay did not close on activation");

    AST_RELAY_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        relay_hold_jumper && $past(relay_hold_jumper) && s_r.mod_on
        |-> s_r.relay_close)
        else $error("relay opened while held and modulator on");

    AST_RELAY_OFF: assert property (@(posedge ref_clk) disable iff (rst)
        !s_r.mod_on |-> !s_r.relay_close)
        else $error("relay closed with modulator off");

    AST_RESET: assert property (@(posedge ref_clk)
        $past(rst) |-> !s_r.mod_on && !s_r.relay_close
                       && s_r.int_cnt == '0)
        else $error("state not cleared by reset");

endmodule : amt_timer

// ---- tb/amt_far_side.sv ----
// amt_far_side: mains wave and station tone seen by the timer.
// assumes ref_clk free-running; decoder output high while tone heard.
`timescale 1ns/1ns
module amt_far_side #(
    parameter int HALF = 4
) (
    // clock
    input  wire logic ref_clk,
    // line and tone
    output logic      line_cycle_in,
    output logic      tone_detect
);
    int ph = 0;
    initial line_cycle_in = 1'b0;
    initial tone_detect = 1'b0;
    // steady mains wave; both timers count its cycles
    always @(posedge ref_clk) begin
        ph <= (ph == HALF - 1) ? 0 : ph + 1;
        if (ph == HALF - 1) line_cycle_in <= ~line_cycle_in;
    end
    // station holds the tone n clocks; 10 or more qualifies
    task automatic send_tone(input int n);
        @(posedge ref_clk) tone_detect <= 1'b1;
        repeat (n) @(posedge ref_clk);
        tone_detect <= 1'b0;
    endtask : send_tone
endmodule : amt_far_side

// ---- tb/announcement_modulator_timer_test.sv ----
// announcement_modulator_timer_test: directed bench of amt_timer.
// assumes amt_far_side gives one line tick every 8 clocks.
`timescale 1ns/1ns
module announcement_modulator_timer_test;
    logic ref_clk = 1'b0, rst = 1'b1, trig_n = 1'b1, canc_n = 1'b1;
    logic tone_en = 1'b0, tone_off = 1'b0, int_j = 1'b0;
    logic hold_j = 1'b0, sel60 = 1'b0;
    logic line, tone, mod_on, relay;
    int   mismatches = 0, compares = 0, cyc = 0, n, m;

    always #10 ref_clk = ~ref_clk;

    // default half period of 4 clocks gives one line tick every 8
    amt_far_side u_amt_far_side (.ref_clk(ref_clk),
        .line_cycle_in(line), .tone_detect(tone));

    // counts shortened; expectations below use these values
    amt_timer #(.ON_SHORT_CYC(4), .ON_LONG_CYC(8), .INT_SHORT_CYC(20),
        .INT_LONG_CYC(40), .RELAY_CYC(3), .TONE_CYC(10)) u_amt_timer (
        .ref_clk(ref_clk), .rst(rst), .line_cycle_in(line),
        .manual_trigger_input_n(trig_n), .manual_cancel_input_n(canc_n),
        .tone_detect(tone), .tone_enable_switch(tone_en),
        .tone_turns_off(tone_off), .interval_jumper(int_j),
        .relay_hold_jumper(hold_j), .on_time_60s_sel(sel60),
        .modulator_on(mod_on), .relay_close(relay));

    task automatic chk(string what, logic seen, logic exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s exp %b seen %b", what, exp, seen);
        end
    endtask : chk

    // t line ticks; mains phase and the cycles spent before the wait
    // started move the end by up to one tick and one cycle early or two cycles late
    task automatic rng(string what, int k, int t);
        chk(what, k >= (t - 1) * 8 - 1 && k <= t * 8 + 2, 1'b1);
    endtask : rng

    task automatic tk(int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : tk

    task automatic wt(bit rl, logic lvl, int lim, output int k);
        k = 0;
        while ((rl ? relay : mod_on) !== lvl && k < lim) begin
            tk(1);
            k++;
        end
    endtask : wt

    // brief grounding of a contact, then check one cycle later
    task automatic act(bit c, string what, logic exp);
        @(posedge ref_clk);
        if (c) canc_n <= 1'b0;
        else trig_n <= 1'b0;
        @(posedge ref_clk);
        if (c) canc_n <= 1'b1;
        else trig_n <= 1'b1;
        tk(1);
        chk(what, mod_on, exp);
    endtask : act

    task automatic tone_chk(int len, string what, logic exp);
        u_amt_far_side.send_tone(len);
        tk(1);
        chk(what, mod_on, exp);
    endtask : tone_chk

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // whole run needs about 2100 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 10000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        tk(1);
        chk("reset mod", mod_on, 1'b0);
        chk("reset relay", relay, 1'b0);
        @(posedge ref_clk) trig_n <= 1'b0;
        tk(2);
        chk("trig on", mod_on, 1'b1);
        chk("relay on", relay, 1'b1);
        wt(1, 0, 99, n);
        rng("relay pulse", n, 3);
        wt(0, 0, 99, m);
        rng("on time", n + m, 4);
        tk(40);
        chk("held trig", mod_on, 1'b0);
        @(posedge ref_clk) trig_n <= 1'b1;
        $display("test trigger done");
        act(0, "trig again", 1'b1);
        @(posedge ref_clk) canc_n <= 1'b0;
        tk(2);
        chk("cancel off", mod_on, 1'b0);
        chk("cancel relay", relay, 1'b0);
        act(0, "trig held cancel", 1'b1);
        @(posedge ref_clk) canc_n <= 1'b1;
        act(1, "cancel again", 1'b0);
        $display("test cancel done");
        @(posedge ref_clk) int_j <= 1'b1;
        wt(0, 1, 400, n);
        rng("auto start", n, 20);
        wt(0, 0, 99, n);
        wt(0, 1, 400, n);
        rng("gap after expiry", n, 20);
        act(1, "cancel auto", 1'b0);
        wt(0, 1, 400, n);
        rng("gap after cancel", n, 20);
        act(1, "cancel auto 2", 1'b0);
        tk(80);
        act(0, "manual with timer", 1'b1);
        @(posedge ref_clk) sel60 <= 1'b1;
        wt(0, 0, 200, n);
        rng("long on", n, 8);
        wt(0, 1, 800, n);
        rng("long gap", n, 40);
        @(posedge ref_clk) int_j <= 1'b0;
        wt(0, 0, 200, n);
        wt(0, 1, 800, n);
        chk("no jumper", mod_on, 1'b0);
        $display("test interval done");
        @(posedge ref_clk) tone_en <= 1'b1;
        tone_chk(8, "short tone", 1'b0);
        tone_chk(12, "tone on", 1'b1);
        tone_chk(12, "tone keeps on", 1'b1);
        @(posedge ref_clk) tone_off <= 1'b1;
        tone_chk(12, "tone off", 1'b0);
        tone_chk(12, "off tone idle", 1'b0);
        @(posedge ref_clk) {tone_en, tone_off} <= 2'b00;
        tone_chk(12, "switch off", 1'b0);
        $display("test tone done");
        @(posedge ref_clk) hold_j <= 1'b1;
        act(0, "hold start", 1'b1);
        tk(40);
        chk("relay held", relay, 1'b1);
        act(1, "hold cancel", 1'b0);
        chk("relay open", relay, 1'b0);
        $display("test relay hold done");
        final_report();
    end
endmodule : announcement_modulator_timer_test
